// [rtl/lsc_regs.vh]
`ifndef LSC_REGS_VH
`define LSC_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LSC_ADDR_W 4
`define LSC_OFF_CTRL 4'h0
`define LSC_OFF_STAT 4'h4
`define LSC_OFF_EVT 4'h8

// ----------------------------------------
// Control fields
// ----------------------------------------
`define LSC_BIT_RGATE 8
`define LSC_BIT_TMODE 9
`define LSC_BIT_ERRDIS 10
`define LSC_BIT_CMPDIS 11
`define LSC_BIT_BSDMODE 6
`define LSC_CTRL_RESET 32'h0000_0000
`define LSC_CTRL_MASK 32'h0000_0F40

// ----------------------------------------
// Event fields
// ----------------------------------------
`define LSC_EVT_BRK 0
`define LSC_EVT_ERR 1
`define LSC_EVT_CMP 3

`endif

// [rtl/lsc_edge.v]
`timescale 1ns/10ps
// ----------------------------------------
// Rising and falling edge detector
// ----------------------------------------
module lsc_edge (
    input wire clk,
    input wire rst_n,
    input wire din,
    output reg rise,
    output reg fall
);
    reg last;

    always @(posedge clk) begin
        if (!rst_n) begin
            last <= 1'b1;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            last <= din;
            rise <= din & ~last;
            fall <= ~din & last;
        end
    end
endmodule

// [rtl/lsc_route.v]
`timescale 1ns/10ps
// ----------------------------------------
// Transceiver path selection
// ----------------------------------------
module lsc_route (
    input wire test_mode,
    input wire uart_txd,
    input wire gpio_tx_in,
    input wire xcvr_rxd,
    output reg xcvr_txd,
    output reg uart_rx_raw,
    output reg gpio_rx_out,
    output reg gpio_rx_oe
);
    always @* begin
        if (test_mode) begin
            xcvr_txd = gpio_tx_in;
            uart_rx_raw = 1'b1;
            gpio_rx_out = xcvr_rxd;
            gpio_rx_oe = 1'b1;
        end else begin
            xcvr_txd = uart_txd;
            uart_rx_raw = xcvr_rxd;
            gpio_rx_out = 1'b1;
            gpio_rx_oe = 1'b0;
        end
    end
endmodule

// [rtl/lsc_top.v]
`timescale 1ns/10ps
`include "lsc_regs.vh"

// Function
// - A set compare-disable bit blocks the break timer compare interrupt.
// - A set error-disable bit (bit 10) blocks the break timer error interrupt.
// - Test-mode bit 9 low connects the transceiver straight to the UART.
// - Test-mode bit high routes two GPIO pins to transceiver TxD and RxD.
// - Receive-gate bit 8 high with bit 6 low holds UART receive high until break and sync.
// - In pulse-width read mode the gate bit raises a break event per rise.
module lsc_top (
    input wire clk,
    input wire rst_n,
    input wire [`LSC_ADDR_W-1:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    input wire uart_txd,
    output reg uart_rxd,
    input wire gpio_tx_in,
    output reg gpio_rx_out,
    output reg gpio_rx_oe,
    input wire xcvr_rxd,
    output reg xcvr_txd,
    input wire break_done,
    input wire sync_done,
    input wire cmp_event,
    input wire err_event,
    output reg cmp_irq,
    output reg err_irq,
    output reg brk_irq
);

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    reg [31:0] ctrl;
    reg [2:0] evt;
    reg [31:0] next_rdata;
    wire cmp_dis = ctrl[`LSC_BIT_CMPDIS];
    wire err_dis = ctrl[`LSC_BIT_ERRDIS];
    wire test_mode = ctrl[`LSC_BIT_TMODE];
    wire rx_gate = ctrl[`LSC_BIT_RGATE];
    wire bsd_mode = ctrl[`LSC_BIT_BSDMODE];

    function hit;
        input [`LSC_ADDR_W-1:0] a;
        input [`LSC_ADDR_W-1:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    always @(posedge clk) begin
        if (!rst_n) begin
            ctrl <= `LSC_CTRL_RESET;
        end else if (wr && hit(addr, `LSC_OFF_CTRL)) begin
            ctrl <= wdata & `LSC_CTRL_MASK;
        end
    end

    // ----------------------------------------
    // Path routing
    // ----------------------------------------
    wire rt_txd;
    wire rt_rx;
    wire rt_gout;
    wire rt_goe;

    lsc_route u_route (
        .test_mode(test_mode),
        .uart_txd(uart_txd),
        .gpio_tx_in(gpio_tx_in),
        .xcvr_rxd(xcvr_rxd),
        .xcvr_txd(rt_txd),
        .uart_rx_raw(rt_rx),
        .gpio_rx_out(rt_gout),
        .gpio_rx_oe(rt_goe)
    );

    // ----------------------------------------
    // Receive gate
    // ----------------------------------------
    // Break and sync seen since the gate was last raised
    reg brk_seen;
    reg sync_seen;
    reg gate_last;

    always @(posedge clk) begin
        if (!rst_n) begin
            brk_seen <= 1'b0;
            sync_seen <= 1'b0;
            gate_last <= 1'b0;
        end else begin
            gate_last <= rx_gate;
            if (rx_gate && !gate_last) begin
                brk_seen <= break_done;
                sync_seen <= 1'b0;
            end else begin
                if (break_done) begin
                    brk_seen <= 1'b1;
                end
                if (sync_done && (brk_seen || break_done)) begin
                    sync_seen <= 1'b1;
                end
            end
        end
    end

    // Stale sync flag from an earlier gate must not open a fresh gate
    wire gate_hold = rx_gate && !bsd_mode && (!sync_seen || !gate_last);

    always @(posedge clk) begin
        if (!rst_n) begin
            uart_rxd <= 1'b1;
            xcvr_txd <= 1'b1;
            gpio_rx_out <= 1'b1;
            gpio_rx_oe <= 1'b0;
        end else begin
            uart_rxd <= gate_hold ? 1'b1 : rt_rx;
            xcvr_txd <= rt_txd;
            gpio_rx_out <= rt_gout;
            gpio_rx_oe <= rt_goe;
        end
    end

    // ----------------------------------------
    // Interrupt gating
    // ----------------------------------------
    wire bus_rise;

    lsc_edge u_edge (
        .clk(clk),
        .rst_n(rst_n),
        .din(xcvr_rxd),
        .rise(bus_rise),
        .fall()
    );

    always @(posedge clk) begin
        if (!rst_n) begin
            cmp_irq <= 1'b0;
            err_irq <= 1'b0;
            brk_irq <= 1'b0;
        end else begin
            cmp_irq <= cmp_event && !cmp_dis;
            err_irq <= err_event && !err_dis;
            brk_irq <= bsd_mode && rx_gate && bus_rise;
        end
    end

    // Sticky event record, set wins over write-one-to-clear
    always @(posedge clk) begin
        if (!rst_n) begin
            evt <= 3'h0;
        end else begin
            if (wr && hit(addr, `LSC_OFF_EVT)) begin
                evt <= (evt & ~wdata[2:0]) |
                       {cmp_irq, err_irq, brk_irq};
            end else begin
                evt <= evt | {cmp_irq, err_irq, brk_irq};
            end
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always @* begin
        next_rdata = 32'h0000_0000;
        if (hit(addr, `LSC_OFF_CTRL)) begin
            next_rdata = ctrl;
        end else if (hit(addr, `LSC_OFF_STAT)) begin
            next_rdata[0] = brk_seen;
            next_rdata[1] = sync_seen;
            next_rdata[2] = gate_hold;
            next_rdata[3] = xcvr_rxd;
        end else if (hit(addr, `LSC_OFF_EVT)) begin
            next_rdata[`LSC_EVT_BRK] = evt[0];
            next_rdata[`LSC_EVT_ERR] = evt[1];
            next_rdata[`LSC_EVT_CMP] = evt[2];
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

endmodule

// [dv/lsc_xcvr_model.sv]
`timescale 1ns/10ps
module lsc_xcvr_model (
    input wire clk,
    input wire txd,
    input wire pull_low,
    output reg rxd
);
initial rxd = 1'b1;
// Wired-AND bus, seen one cycle late
always @(posedge clk) begin
    rxd <= txd & ~pull_low;
end
endmodule

// [dv/lsc_top_sva.sv]
`timescale 1ns/10ps
module lsc_top_sva (
    input wire clk,
    input wire rst_n,
    input wire [3:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire uart_txd,
    input wire uart_rxd,
    input wire gpio_tx_in,
    input wire gpio_rx_out,
    input wire gpio_rx_oe,
    input wire xcvr_rxd,
    input wire xcvr_txd,
    input wire break_done,
    input wire cmp_event,
    input wire err_event,
    input wire cmp_irq,
    input wire err_irq,
    input wire brk_irq
);
reg [11:0] sh;
reg bs;
wire wc = wr && addr == 4'h0;
always @(posedge clk) begin
    if (!rst_n) sh <= 12'h000;
    else if (wc) sh <= wdata[11:0];
end
always @(posedge clk) begin
    if (!rst_n || (wc && wdata[8] && !sh[8])) bs <= 1'b0;
    else if (break_done) bs <= 1'b1;
end
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
sequence s_hold;
    sh[8] && !sh[6] && !sh[9] && !bs;
endsequence
sequence s_rise;
    sh[6] && sh[8] && $rose(xcvr_rxd);
endsequence
a_cmp_irq_gate: assert property (
    ##1 cmp_irq == $past(cmp_event && !sh[11])) else $error("cmp irq");
a_err_irq_gate: assert property (
    ##1 err_irq == $past(err_event && !sh[10])) else $error("err irq");
a_txd_route: assert property (
    ##1 xcvr_txd == $past(sh[9] ? gpio_tx_in : uart_txd)) else $error("txd");
a_rxd_normal: assert property (
    !sh[9] && !sh[8] |=> uart_rxd == $past(xcvr_rxd)) else $error("rxd");
a_test_pins: assert property (
    sh[9] |=> gpio_rx_oe && uart_rxd && gpio_rx_out == $past(xcvr_rxd))
    else $error("test mode pins");
a_gate_hold: assert property (s_hold |=> uart_rxd)
    else $error("gate");
a_bsd_break: assert property (s_rise |-> ##2 brk_irq)
    else $error("break irq");
a_reset_idle: assert property (disable iff (1'b0)
    !rst_n |=> uart_rxd && xcvr_txd && !gpio_rx_oe && !brk_irq)
    else $error("reset");
endmodule

// [dv/lin_sync_control_bits_test.sv]
`timescale 1ns/10ps
module lin_sync_control_bits_test;
reg clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ml = 1'b0;
reg [3:0] addr = 4'h0;
reg [31:0] wdata = 32'h0000_0000, d;
reg uart_txd = 1'b1, gpio_tx_in = 1'b1, break_done = 1'b0;
reg sync_done = 1'b0, cmp_event = 1'b0, err_event = 1'b0;
wire [31:0] rdata;
wire uart_rxd, gpio_rx_out, gpio_rx_oe, xcvr_rxd, xcvr_txd;
wire cmp_irq, err_irq, brk_irq;
integer seed = 60, bad_count = 0, tests_run = 0, i, n;
always #5 clk = ~clk;
lsc_top u_dut (.*);
lsc_xcvr_model u_xcvr (.clk(clk), .txd(xcvr_txd), .pull_low(ml),
    .rxd(xcvr_rxd));
function [31:0] irq_exp(input [31:0] c);
    irq_exp = {30'h0, ~c[11], ~c[10]};
endfunction
task check(input [31:0] s, input [31:0] e);
    tests_run = tests_run + 1;
    if (s !== e) begin
        bad_count = bad_count + 1;
        $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
endtask
task wreg(input [3:0] a, input [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
endtask
task rreg(input [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
endtask
task pulse(input [3:0] m);
    @(posedge clk);
    {break_done, sync_done, cmp_event, err_event} <= m;
    @(posedge clk);
    {break_done, sync_done, cmp_event, err_event} <= 4'h0;
endtask
task step(input integer c);
    repeat (c) @(posedge clk);
    #1;
endtask
task complete_run;
    $display("Mismatches %0d of %0d checks", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
initial begin
    #100000;
    bad_count = bad_count + 1;
    complete_run;
end
initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rreg(4'h0);
    check(d, 32'h0000_0000);
    rreg(4'hC);
    check(d, 32'h0000_0000);
    for (i = 0; i < 8; i = i + 1) begin
        d = $random(seed) & 32'h0000_0C00;
        if (i < 4) d = {20'h0_0000, i[1:0], 10'h000};
        wreg(4'h0, d);
        pulse(4'h3);
        #1 check({cmp_irq, err_irq}, irq_exp(d));
    end
    rreg(4'h8);
    check(d, 32'h0000_000A);
    wreg(4'h8, 32'h0000_000F);
    rreg(4'h8);
    check(d, 32'h0000_0000);
    for (i = 0; i < 16; i = i + 1) begin
        if (i % 8 == 0) wreg(4'h0, {22'h0, i[3], 9'h000});
        @(posedge clk);
        d = $random(seed);
        uart_txd <= d[0];
        gpio_tx_in <= d[1];
        ml <= d[2];
        step(1);
        check(xcvr_txd, i[3] ? gpio_tx_in : uart_txd);
        check(gpio_rx_oe, i[3]);
        if (i[3]) check(uart_rxd, 1'b1);
        else check(gpio_rx_out, 1'b1);
    end
    wreg(4'h0, 32'h0000_0100);
    uart_txd <= 1'b1;
    ml <= 1'b1;
    pulse(4'h4);
    step(3);
    check(uart_rxd, 1'b1);
    pulse(4'h8);
    step(3);
    check(uart_rxd, 1'b1);
    pulse(4'h4);
    step(3);
    check(uart_rxd, 1'b0);
    wreg(4'h0, 32'h0000_0000);
    for (i = 0; i < 2; i = i + 1) begin
        wreg(4'h0, i ? 32'h0000_0040 : 32'h0000_0140);
        ml <= 1'b1;
        step(4);
        n = 0;
        ml <= 1'b0;
        repeat (6) begin
            step(1);
            n = n + brk_irq;
        end
        check(n, i ? 0 : 1);
    end
    complete_run;
end
endmodule
bind lsc_top lsc_top_sva u_sva (.*);
